// ### verilog/floppy_host_command_port.v
// processor-side port of a dual floppy subsystem: decodes the 675x group,
// holds the command word, flags, interrupt enable and maintenance state.
// assumes ioStrobe pulses one cycle per instruction and the drive
// controller handshakes with go/ack and reports done/fault levels.
`timescale 1ns/10ps
`include "floppy_port_regs.vh"

module floppy_host_command_port
(
  input wire sys_clk,
  input wire resetn,
  input wire ioStrobe,
  input wire [2:0] ioOp,
  input wire [11:0] acIn,
  output reg [11:0] acOut,
  output wire acLoad,
  output wire skipTaken,
  output wire irqRequest,
  output reg pairSelect,
  output reg unitChoiceBit,
  output reg eightBitMode,
  output reg [2:0] funcCode,
  output reg [11:0] ifaceWord,
  output reg maintActive,
  output reg busy,
  output reg wordRequestFlag,
  output reg faultFlag,
  output reg completeFlag,
  output reg irqEnable,
  output reg [6:0] wordIndex,
  output reg bufWrite,
  input wire [11:0] bufReadData,
  input wire [11:0] statusWord,
  input wire driveGoAck,
  input wire driveDone,
  input wire driveFault,
  input wire [11:0] driveWord,
  output reg driveGo,
  output reg driveAck
);

  localparam ST_IDLE = 3'h0;
  localparam ST_WAIT_REQ = 3'h1;
  localparam ST_GAP = 3'h2;
  localparam ST_FINISH = 3'h3;
  localparam ST_DRIVE = 3'h4;

  reg rstMeta;
  reg rstSync;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [13:0] gapCount_reg;
  reg [11:0] extended_status_word;

  // returns 1 when op code matches a strobed instruction
  function isOp;
    input strobe;
    input [2:0] op;
    input [2:0] want;
    begin
      isOp = strobe & (op == want);
    end
  endfunction

  wire opSelect = isOp(ioStrobe, ioOp, `OP_SELECT);
  wire opLoad = isOp(ioStrobe, ioOp, `OP_COMMAND_LOAD);
  wire opMove = isOp(ioStrobe, ioOp, `OP_DATA_WORD_MOVE);
  wire opSkipReq = isOp(ioStrobe, ioOp, `OP_SKIP_REQUEST);
  wire opSkipFault = isOp(ioStrobe, ioOp, `OP_SKIP_FAULT);
  wire opSkipDone = isOp(ioStrobe, ioOp, `OP_SKIP_COMPLETE);
  wire opIrq = isOp(ioStrobe, ioOp, `OP_IRQ_ENABLE_WRITE);
  wire opInit = isOp(ioStrobe, ioOp, `OP_INITIALIZE);
  wire loadMaint = acIn[`AC_BIT4];
  wire [2:0] newFunc = acIn[`FUNC_MSB:`FUNC_LSB];
  wire fnBuffer = (funcCode == `FN_FILL) | (funcCode == `FN_EMPTY);
  wire [6:0] lastIndex = eightBitMode ? `LAST_8BIT : `LAST_12BIT; // R8
  wire [13:0] gapCycles = eightBitMode ? `GAP_8BIT_CYC : `GAP_12BIT_CYC; // R9
  // new function accepted only when no function runs; maintActive loads on every command load,
  // ifaceWord too unless an empty-buffer start, an empty-buffer gap end, ST_FINISH or drive done overwrites it
  wire loadOk = opLoad & ~busy; // R4 R22

  // skip answers combinationally in the instruction cycle
  assign skipTaken = (opSkipReq & wordRequestFlag) | (opSkipFault & faultFlag)
    | (opSkipDone & completeFlag); // R11 R25
  assign irqRequest = completeFlag & irqEnable; // R16
  assign acLoad = opLoad | opMove; // R2

  // reset release through two flops
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // sequencer for buffer and drive functions
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (loadOk & ~loadMaint)
          state_next = (newFunc == `FN_FILL || newFunc == `FN_EMPTY) ? ST_WAIT_REQ : ST_DRIVE; // R3
      ST_WAIT_REQ:
        if (opMove & ~maintActive)
          state_next = (wordIndex == lastIndex) ? ST_FINISH : ST_GAP; // R10
      ST_GAP:
        if (gapCount_reg == 14'h0001)
          state_next = ST_WAIT_REQ; // R9
      ST_FINISH:
        state_next = ST_IDLE;
      ST_DRIVE:
        if (driveDone)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
    if (opInit)
      state_next = ST_IDLE;
  end

  // main register process
  always @(posedge sys_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      state_reg <= ST_IDLE;
      gapCount_reg <= 14'h0000;
      acOut <= `ZERO12;
      pairSelect <= 1'b0;
      unitChoiceBit <= 1'b0;
      eightBitMode <= 1'b0;
      funcCode <= `FN_FILL;
      ifaceWord <= `ZERO12;
      maintActive <= 1'b0;
      busy <= 1'b0;
      wordRequestFlag <= 1'b0;
      faultFlag <= 1'b0;
      completeFlag <= 1'b0;
      irqEnable <= 1'b0;
      wordIndex <= 7'h00;
      bufWrite <= 1'b0;
      driveGo <= 1'b0;
      driveAck <= 1'b0;
      extended_status_word <= `ZERO12;
    end
    else
    begin
      state_reg <= state_next;
      bufWrite <= 1'b0;
      driveAck <= 1'b0;
      acOut <= `ZERO12; // R2
      if (driveGoAck)
        driveGo <= 1'b0;
      if (opSelect)
        pairSelect <= acIn[`AC_BIT11]; // R1
      if (opIrq)
        irqEnable <= acIn[`AC_BIT11]; // R12
      if (opLoad)
      begin
        ifaceWord <= acIn; // R2 R18
        maintActive <= loadMaint; // R13 R14
      end
      if (loadOk & ~loadMaint)
      begin
        unitChoiceBit <= acIn[`AC_BIT7]; // R5
        eightBitMode <= acIn[`AC_BIT5]; // R6
        funcCode <= newFunc; // R7
        busy <= 1'b1;
        completeFlag <= 1'b0;
        faultFlag <= 1'b0;
        wordIndex <= 7'h00;
        // status copy taken from the drive at function start
        if (newFunc == `FN_EMPTY)
        begin
          extended_status_word <= statusWord & `STATUS_CLEAR_MASK; // R23
          ifaceWord <= bufReadData;
        end
        else
          extended_status_word <= statusWord; // R21
        if (newFunc == `FN_FILL || newFunc == `FN_EMPTY)
          wordRequestFlag <= 1'b1; // R20
        else
          driveGo <= 1'b1; // R3
      end
      // skip clears its flag outside maintenance
      if (skipTaken & ~maintActive)
      begin
        if (opSkipReq)
          wordRequestFlag <= 1'b0; // R25
        if (opSkipFault)
          faultFlag <= 1'b0;
        if (opSkipDone)
          completeFlag <= 1'b0;
      end
      // data word move
      if (opMove)
      begin
        if (maintActive | completeFlag | funcCode != `FN_FILL)
          acOut <= ifaceWord; // R13 R21 R24
        if (~maintActive & busy & fnBuffer & state_reg == ST_WAIT_REQ)
        begin
          if (funcCode == `FN_FILL)
          begin
            ifaceWord <= eightBitMode ? {4'h0, acIn[7:0]} : acIn; // R8 R24
            bufWrite <= 1'b1; // R20
          end
          gapCount_reg <= gapCycles;
        end
        else if (~maintActive & busy)
          driveAck <= 1'b1; // R24
      end
      if (state_reg == ST_GAP)
      begin
        gapCount_reg <= gapCount_reg - 14'h0001;
        if (gapCount_reg == 14'h0001)
        begin
          wordIndex <= wordIndex + 7'h01;
          wordRequestFlag <= 1'b1; // R20 R23
          if (funcCode == `FN_EMPTY)
            ifaceWord <= bufReadData;
        end
      end
      if (state_reg == ST_FINISH)
      begin
        ifaceWord <= extended_status_word; // R21
        completeFlag <= 1'b1; // R22
        busy <= 1'b0;
      end
      if (state_reg == ST_DRIVE && driveDone)
      begin
        extended_status_word <= statusWord;
        ifaceWord <= (funcCode == `FN_ERROR_REG) ? driveWord : statusWord;
        completeFlag <= 1'b1;
        faultFlag <= driveFault; // R26
        busy <= 1'b0;
        driveGo <= 1'b0;
      end
      // maintenance forces skip flags, overriding skip and load clears; initialize still clears
      if (maintActive)
      begin
        wordRequestFlag <= 1'b1; // R15
        faultFlag <= 1'b1;
        completeFlag <= 1'b1;
      end
      if (opInit)
      begin
        wordRequestFlag <= 1'b0; // R17
        faultFlag <= 1'b0;
        completeFlag <= 1'b0;
        irqEnable <= 1'b0;
        maintActive <= 1'b0; // R14 R19
        busy <= 1'b0;
        driveGo <= 1'b0;
      end
    end
  end

endmodule // floppy_host_command_port

// ### verilog/floppy_port_regs.vh
// constants for the floppy host command port: instruction codes, command
// word fields, function codes and transfer timing.
// assumes a 25 MHz sys_clk and 12-bit accumulator words, bit 0 as msb.
//
// Behaviour
// R1: select instruction picks drive pair A for accumulator bit 11 zero, else B.
// R2: command load copies accumulator into interface register, then clears accumulator.
// R3: command load with bit 4 zero starts function in bits 8-10 on chosen drive.
// R4: no new function starts while previous one runs; processor waits.
// R5: command bit 7 chooses drive 0 or drive 1.
// R6: command bit 5 chooses 12-bit words (0) or 8-bit words (1).
// R7: function codes: fill, empty, write, read, unused, status, deleted write, error reg.
// R8: sector holds 64 words in 12-bit mode, 128 in 8-bit; pad with zeros.
// R9: next word request comes 23 us (12-bit) or 18 us (8-bit) after service.
// R10: pending word request waits forever for the processor.
// R11: skip instructions test word-request, fault and complete flags.
// R12: irq enable write loads interrupt enable from accumulator bit 11.
// R13: command load with bit 4 set sets maintenance; go suppressed, data to accumulator.
// R14: maintenance cleared by initialize or command load with bit 4 zero.
// R15: maintenance forces skip flags set; skips keep them; they stay set after.
// R16: interrupt request whenever complete flag and interrupt enable are both set.
// R17: initialize clears every flag and the interrupt enable.
// R18: interface register holds loaded value after command loads in maintenance.
// R19: processor leaves maintenance with initialize; uses it only for register loopback.
// R20: fill buffer requests each word; processor skips, then supplies; device stores.
// R21: after last word status goes to interface register and complete sets.
// R22: complete and new commands wait for full word count.
// R23: empty buffer clears status bits 10,11, presents each word with request set.
// R24: data word move exchanges one word per direction line, mode length, acknowledges drive.
// R25: skip with flag set advances past one instruction, clears flag outside maintenance.
// R26: fault flag sets together with complete when the drive reports a failure.
`ifndef FLOPPY_PORT_REGS_VH
`define FLOPPY_PORT_REGS_VH

// instruction low octal digit (device code 75 decoded outside)
`define OP_SELECT 3'h0
`define OP_COMMAND_LOAD 3'h1
`define OP_DATA_WORD_MOVE 3'h2
`define OP_SKIP_REQUEST 3'h3
`define OP_SKIP_FAULT 3'h4
`define OP_SKIP_COMPLETE 3'h5
`define OP_IRQ_ENABLE_WRITE 3'h6
`define OP_INITIALIZE 3'h7

// accumulator bit n (msb-first numbering) is vector index 11-n
`define AC_BIT11 0
`define AC_BIT4 7
`define AC_BIT5 6
`define AC_BIT7 4
`define FUNC_LSB 1
`define FUNC_MSB 3

// function codes
`define FN_FILL 3'h0
`define FN_EMPTY 3'h1
`define FN_WRITE 3'h2
`define FN_READ 3'h3
`define FN_UNUSED 3'h4
`define FN_STATUS 3'h5
`define FN_WRITE_DEL 3'h6
`define FN_ERROR_REG 3'h7

// sector lengths in words
`define WORDS_12BIT 8'h40
`define WORDS_8BIT 8'h80
`define LAST_12BIT 7'h3f
`define LAST_8BIT 7'h7f

// status bits 10 and 11 cleared by empty buffer
`define STATUS_CLEAR_MASK 12'hffc

// word request spacing
`define CLK_MHZ 25
`define GAP_12BIT_US 23
`define GAP_8BIT_US 18
// cycle counts sized to the 14-bit gap counter: 23 us and 18 us at 25 MHz
`define GAP_12BIT_CYC 14'h023f
`define GAP_8BIT_CYC 14'h01c2

`define ZERO12 12'h000

`endif

// ### testbench/floppy_port_sva.sv
// assertions on the pins of the floppy host command port
// assumes the port header is on the include path and one clock domain
`timescale 1ns/10ps
`include "floppy_port_regs.vh"
module floppy_port_sva
(
  input wire sys_clk,
  input wire resetn,
  input wire ioStrobe,
  input wire [2:0] ioOp,
  input wire [11:0] acIn,
  input wire [11:0] acOut,
  input wire acLoad,
  input wire skipTaken,
  input wire irqRequest,
  input wire pairSelect,
  input wire eightBitMode,
  input wire maintActive,
  input wire wordRequestFlag,
  input wire faultFlag,
  input wire completeFlag,
  input wire irqEnable,
  input wire bufWrite,
  input wire [11:0] ifaceWord,
  input wire driveAck
);
  reg [10:0] gapCnt_reg;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_iot(logic [2:0] op);
    ioStrobe && ioOp == op;
  endsequence
  // cycles since the last word went to the buffer, saturating
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      gapCnt_reg <= 11'h7ff;
    else if (bufWrite)
      gapCnt_reg <= 11'h000;
    else if (gapCnt_reg != 11'h7ff)
      gapCnt_reg <= gapCnt_reg + 11'h001;
  end
  a_irq_level: assert property (irqRequest == (completeFlag && irqEnable))
    else $error("irq request not done and enable");
  a_load_clears_ac: assert property (s_iot(`OP_COMMAND_LOAD) |-> acLoad ##1 acOut == 12'h000)
    else $error("command load did not clear accumulator");
  a_maint_set: assert property (s_iot(`OP_COMMAND_LOAD) ##0 acIn[`AC_BIT4] |=> maintActive)
    else $error("maintenance not set");
  a_init_clears: assert property (s_iot(`OP_INITIALIZE) |=> !maintActive && !irqEnable
    && !completeFlag && !wordRequestFlag && !faultFlag)
    else $error("initialize left state set");
  a_maint_flags: assert property (maintActive && $past(maintActive)
    |-> wordRequestFlag && faultFlag && completeFlag)
    else $error("flags not forced in maintenance");
  a_irq_write: assert property (s_iot(`OP_IRQ_ENABLE_WRITE) |=> irqEnable == $past(acIn[0]))
    else $error("irq enable not loaded");
  a_pair_select: assert property (s_iot(`OP_SELECT) |=> pairSelect == $past(acIn[0]))
    else $error("pair select wrong");
  a_skip_match: assert property (s_iot(`OP_SKIP_REQUEST) |-> skipTaken == wordRequestFlag)
    else $error("skip does not follow request flag");
  a_skip_clear: assert property (s_iot(`OP_SKIP_REQUEST) ##0 wordRequestFlag && !maintActive
    |=> !wordRequestFlag)
    else $error("skip did not clear flag");
  a_word_gap: assert property ($rose(wordRequestFlag) && !maintActive |-> gapCnt_reg + 11'h005
    >= (eightBitMode ? `GAP_8BIT_CYC : `GAP_12BIT_CYC))
    else $error("word request came too early");
  a_move_maint: assert property (s_iot(`OP_DATA_WORD_MOVE) ##0 maintActive
    |=> acOut == $past(ifaceWord) && !driveAck)
    else $error("maintenance move wrong");
endmodule // floppy_port_sva
bind floppy_host_command_port floppy_port_sva u_sva (.sys_clk, .resetn, .ioStrobe, .ioOp,
  .acIn, .acOut, .acLoad, .skipTaken, .irqRequest, .pairSelect, .eightBitMode, .maintActive,
  .wordRequestFlag, .faultFlag, .completeFlag, .irqEnable, .bufWrite, .ifaceWord, .driveAck);

// ### testbench/floppy_drive_model.sv
// drive controller and sector buffer model facing the port
// assumes one sys_clk; drive functions never finish, initialize ends them
`timescale 1ns/10ps
module floppy_drive_model
#(
  parameter [11:0] STATUS_WORD = 12'h5a3
)
(
  input wire sys_clk,
  input wire resetn,
  input wire driveGo,
  input wire bufWrite,
  input wire [6:0] wordIndex,
  input wire [11:0] ifaceWord,
  output reg driveGoAck,
  output wire driveDone,
  output wire driveFault,
  output wire [11:0] driveWord,
  output wire [11:0] bufReadData,
  output wire [11:0] statusWord
);
  reg [11:0] mem [0:127];
  // sector buffer keeps each word handed over
  always @(posedge sys_clk)
  begin
    if (bufWrite)
      mem[wordIndex] <= ifaceWord;
  end
  // go answered one cycle later
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      driveGoAck <= 1'b0;
    else
      driveGoAck <= driveGo;
  end
  // status and buffer read back
  assign bufReadData = mem[wordIndex];
  assign statusWord = STATUS_WORD;
  assign driveWord = ~STATUS_WORD;
  assign driveDone = 1'b0;
  assign driveFault = 1'b0;
endmodule // floppy_drive_model

// ### testbench/tb.sv
// self-checking bench for the floppy host command port
// assumes the design, its header and the drive model are compiled first
`timescale 1ns/10ps
`include "floppy_port_regs.vh"
module tb;
  localparam [11:0] STAT = 12'h5a3;
  reg sys_clk = 1'b0;
  reg resetn = 1'b0;
  reg ioStrobe = 1'b0;
  reg [2:0] ioOp = 3'h0;
  reg [11:0] acIn = 12'h000;
  reg [11:0] lfsr = 12'h044;
  reg [11:0] cmd;
  reg [11:0] q [$];
  reg sk;
  integer err_count = 0;
  integer comparisons = 0;
  integer cyc = 0;
  integer n = 0;
  integer i;
  integer k;
  wire [11:0] acOut, ifaceWord, bufReadData, statusWord, driveWord;
  wire [6:0] wordIndex;
  wire [2:0] funcCode;
  wire acLoad, skipTaken, irqRequest, pairSelect, unitChoiceBit, eightBitMode, maintActive;
  wire busy, wordRequestFlag, faultFlag, completeFlag, irqEnable, bufWrite, driveGoAck;
  wire driveDone, driveFault, driveGo, driveAck;
  floppy_host_command_port DUT (.sys_clk, .resetn, .ioStrobe, .ioOp, .acIn, .acOut, .acLoad,
    .skipTaken, .irqRequest, .pairSelect, .unitChoiceBit, .eightBitMode, .funcCode, .ifaceWord,
    .maintActive, .busy, .wordRequestFlag, .faultFlag, .completeFlag, .irqEnable, .wordIndex,
    .bufWrite, .bufReadData, .statusWord, .driveGoAck, .driveDone, .driveFault, .driveWord,
    .driveGo, .driveAck);
  floppy_drive_model #(.STATUS_WORD(STAT)) partner (.sys_clk, .resetn, .driveGo, .bufWrite,
    .wordIndex, .ifaceWord, .driveGoAck, .driveDone, .driveFault, .driveWord, .bufReadData,
    .statusWord);
  always #20 sys_clk = ~sys_clk;
  function [11:0] nxt(input [11:0] x);
    nxt = {x[10:0], x[11] ^ x[10] ^ x[9] ^ x[3]};
  endfunction
  task check(input [11:0] got, input [11:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // one instruction, skip result caught in its strobe cycle
  task iot(input [2:0] op, input [11:0] ac);
    begin
      @(posedge sys_clk);
      ioStrobe <= 1'b1;
      ioOp <= op;
      acIn <= ac;
      #1 sk = skipTaken;
      @(posedge sys_clk);
      ioStrobe <= 1'b0;
      #1;
    end
  endtask
  task wait_flag;
    begin
      k = 0;
      while (wordRequestFlag !== 1'b1 && completeFlag !== 1'b1 && k < 700)
      begin
        @(posedge sys_clk);
        #1 k = k + 1;
      end
    end
  endtask
  task close_out;
    begin
      if (err_count == 0 && comparisons > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // hang guard
  always @(posedge sys_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 50000)
    begin
      err_count = err_count + 1;
      close_out;
    end
  end
  // reference queue against each buffered word
  always @(posedge sys_clk)
  begin
    if (bufWrite === 1'b1)
    begin
      check(ifaceWord, q.pop_front());
      check({5'h00, wordIndex}, n);
      n = n + 1;
    end
  end
  initial
  begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (i = 0; i < 2; i = i + 1)
    begin
      iot(`OP_SELECT, i);
      check(pairSelect, i);
    end
    iot(`OP_IRQ_ENABLE_WRITE, 12'h001);
    check(irqEnable, 1);
    lfsr = nxt(lfsr);
    iot(`OP_COMMAND_LOAD, lfsr | 12'h080);
    check(maintActive, 1);
    lfsr = nxt(lfsr);
    cmd = lfsr | 12'h080;
    iot(`OP_COMMAND_LOAD, cmd);
    check(ifaceWord, cmd);
    iot(`OP_DATA_WORD_MOVE, 12'h000);
    check(acOut, cmd);
    for (i = 3; i < 6; i = i + 1)
    begin
      iot(i, 12'h000);
      check(sk, 1);
    end
    check(irqRequest, 1);
    iot(`OP_COMMAND_LOAD, 12'h00e);
    check({maintActive, funcCode}, 7);
    iot(`OP_INITIALIZE, 12'h000);
    check({wordRequestFlag, faultFlag, completeFlag, irqEnable, maintActive}, 0);
    lfsr = nxt(lfsr);
    cmd = lfsr & 12'hf31;
    iot(`OP_COMMAND_LOAD, cmd);
    check(acOut, 0);
    check({busy, funcCode, unitChoiceBit, eightBitMode}, {4'h8, cmd[4], 1'b0});
    for (i = 0; i < `WORDS_12BIT; i = i + 1)
    begin
      wait_flag;
      if (i == 10)
        repeat (2000) @(posedge sys_clk);
      iot(`OP_SKIP_REQUEST, 12'h000);
      check(sk, 1);
      lfsr = nxt(lfsr);
      q.push_back(lfsr);
      iot(`OP_DATA_WORD_MOVE, lfsr);
    end
    wait_flag;
    check(n, 64);
    check(ifaceWord, STAT);
    iot(`OP_DATA_WORD_MOVE, 12'h000);
    check(acOut, STAT);
    iot(`OP_SKIP_COMPLETE, 12'h000);
    check({sk, completeFlag}, 2);
    close_out;
  end
endmodule // tb
